/* File: acc_analog_model.sv */
`timescale 1ns/10ps
module acc_analog_model (
  // control from the block
  input  wire logic comparator_on,
  input  wire logic reference_select,
  // levels in millivolts
  input  var  int   pos_mv,
  input  var  int   neg_mv,
  input  var  int   bandgap_mv,
  // result
  output logic      comparator_raw = 1'b0
);
  // when off the result is meaningless, so show the inverse of the last one
  always @(comparator_on, reference_select, pos_mv, neg_mv, bandgap_mv) begin
    if (comparator_on) begin
      comparator_raw = (reference_select ? bandgap_mv : pos_mv) > neg_mv;
    end else begin
      comparator_raw = ~comparator_raw;
    end
  end
endmodule : acc_analog_model

/* File: acc_comparator_ctrl.sv */
`timescale 1ns/10ps
`include "acc_consts.svh"

module acc_comparator_ctrl
  import acc_pkg::*;
(
  // apb clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`ACC_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // analog comparator
  input  wire logic                   comparator_raw,
  output logic                        comparator_on,
  output logic                        reference_select,
  // low power
  input  wire logic                   stop_mode,
  // output pin
  output logic                        comparator_output_pin_o,
  output logic                        comparator_output_pin_oe_n,
  // interrupts
  output logic                        compare_irq,
  output logic                        irq
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  logic      comparator_enable_ff;
  logic      reference_select_ff;
  logic      compare_event_flag_ff;
  logic      compare_irq_enable_ff;
  logic      output_pin_enable_ff;
  acc_mode_e event_edge_mode_ff;
  logic      sync1_ff;
  logic      sync2_ff;
  logic      level_ff;
  logic      irq_status_ff;
  logic      irq_mask_ff;
  logic      access_ff;

  // ---------------------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------------------
  wire       setup_req   = psel & ~penable;
  wire       wr_done     = psel & penable & pwrite & pready;
  wire       hit_ctrl    = (paddr == `ACC_OFF_CTRL);
  wire       hit_stat    = (paddr == `ACC_OFF_IRQ_STATUS);
  wire       hit_mask    = (paddr == `ACC_OFF_IRQ_MASK);
  wire       hit_any     = hit_ctrl | hit_stat | hit_mask;
  wire       wr_ctrl     = wr_done & hit_ctrl & pstrb[0];
  wire       wr_stat     = wr_done & hit_stat & pstrb[0];
  wire       wr_mask     = wr_done & hit_mask & pstrb[0];

  // stop mode overrides the enable without touching the stored bit
  wire       run         = comparator_enable_ff & ~stop_mode;

  // ---------------------------------------------------------------------------
  // edge detection
  // ---------------------------------------------------------------------------
  // level_ff holds the last synchronised level; it is zero while stopped so
  // re-enabling against a high input looks like a rising edge, a known trade-off
  wire       nxt_level   = run & sync2_ff;
  wire       rise        = run & sync2_ff & ~level_ff;
  wire       fall        = run & ~sync2_ff & level_ff;
  wire       edge_hit    = (event_edge_mode_ff == ACC_MODE_RISE)   ? rise :
                           (event_edge_mode_ff == ACC_MODE_EITHER) ? (rise | fall) :
                           fall;
  wire       flag_clr    = wr_ctrl & pwdata[`ACC_BIT_FLAG];
  // set beats a simultaneous clear so no event is lost
  wire       nxt_flag    = edge_hit | (compare_event_flag_ff & ~flag_clr);
  wire       nxt_status  = edge_hit | (irq_status_ff & ~(wr_stat & pwdata[`ACC_IRQ_BIT_EVENT]));

  // ---------------------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------------------
  wire [7:0] ctrl_rd     = {comparator_enable_ff, reference_select_ff, compare_event_flag_ff,
                            compare_irq_enable_ff, level_ff, output_pin_enable_ff,
                            event_edge_mode_ff};
  // writes and unmapped reads answer with zero data so an error never carries stale data
  wire [31:0] nxt_prdata = ~setup_req ? prdata :
                           (pwrite | ~hit_any) ? 32'h00000000 :
                           hit_ctrl ? {24'h000000, ctrl_rd} :
                           hit_stat ? {31'h00000000, irq_status_ff} :
                           hit_mask ? {31'h00000000, irq_mask_ff} : 32'h00000000;

  // ---------------------------------------------------------------------------
  // apb handshake: no wait state, answer in the cycle after setup
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      access_ff <= 1'b0;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= 32'h00000000;
    end else begin
      access_ff <= setup_req;
      pready    <= setup_req;
      pslverr   <= setup_req & ~hit_any;
      prdata    <= nxt_prdata;
    end
  end

  // ---------------------------------------------------------------------------
  // control register; the level bit ignores writes
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comparator_enable_ff  <= 1'b0;
      reference_select_ff   <= 1'b0;
      compare_irq_enable_ff <= 1'b0;
      output_pin_enable_ff  <= 1'b0;
      event_edge_mode_ff    <= ACC_MODE_FALL0;
    end else if (wr_ctrl) begin
      comparator_enable_ff  <= pwdata[`ACC_BIT_ENABLE];
      reference_select_ff   <= pwdata[`ACC_BIT_REFSEL];
      compare_irq_enable_ff <= pwdata[`ACC_BIT_IRQEN];
      output_pin_enable_ff  <= pwdata[`ACC_BIT_PINEN];
      event_edge_mode_ff    <= acc_mode_e'(pwdata[`ACC_MODE_HI:`ACC_MODE_LO]);
    end
  end

  // ---------------------------------------------------------------------------
  // synchroniser, level and flag; sync1_ff feeds only sync2_ff
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff              <= 1'b0;
      sync2_ff              <= 1'b0;
      level_ff              <= 1'b0;
      compare_event_flag_ff <= 1'b0;
      irq_status_ff         <= 1'b0;
      irq_mask_ff           <= 1'b0;
    end else begin
      sync1_ff              <= comparator_raw;
      sync2_ff              <= sync1_ff;
      level_ff              <= nxt_level;
      compare_event_flag_ff <= nxt_flag;
      irq_status_ff         <= nxt_status;
      irq_mask_ff           <= wr_mask ? pwdata[`ACC_IRQ_BIT_EVENT] : irq_mask_ff;
    end
  end

  // ---------------------------------------------------------------------------
  // registered outputs to the analog side, pin and interrupts
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comparator_on              <= 1'b0;
      reference_select           <= 1'b0;
      comparator_output_pin_o    <= 1'b0;
      comparator_output_pin_oe_n <= 1'b1;
      compare_irq                <= 1'b0;
      irq                        <= 1'b0;
    end else begin
      comparator_on              <= run;
      reference_select           <= reference_select_ff;
      comparator_output_pin_o    <= nxt_level;
      comparator_output_pin_oe_n <= ~output_pin_enable_ff;
      compare_irq                <= compare_irq_enable_ff & nxt_flag;
      irq                        <= irq_mask_ff & nxt_status;
    end
  end

endmodule : acc_comparator_ctrl

/* File: acc_comparator_ctrl_checker.sv */
`timescale 1ns/10ps
module acc_comparator_ctrl_checker (
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // comparator
  input wire logic        comparator_raw,
  input wire logic        comparator_on,
  input wire logic        reference_select,
  input wire logic        stop_mode,
  input wire logic        comparator_output_pin_o
);
  default clocking dcb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // bus answers: one wait-free access, errors carry zero data
  access_ready_a: assert property (psel && !penable |=> pready) else $error("no answer to setup");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held too long");
  error_data_a: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error answer");
  refsel_write_a: assert property ($changed(reference_select) |->
    $past(psel && penable && pwrite && pready) || $past(psel && penable && pwrite && pready, 2))
    else $error("select moved without a write");
  // stop and disable keep the comparator and its level off
  stop_off_a: assert property (stop_mode |=> !comparator_on) else $error("on in stop");
  off_level_a: assert property (!comparator_on [*4] |-> !comparator_output_pin_o) else $error("level while off");
  // two sync flops: the level may never follow the raw result sooner than this
  sync_depth_a: assert property ($rose(comparator_output_pin_o) |-> $past(comparator_raw, 3))
    else $error("level rose too soon");
  follow_high_a: assert property ($rose(comparator_raw) ##0 (comparator_on && comparator_raw) [*5]
    |-> comparator_output_pin_o) else $error("level missed a rise");
  follow_low_a: assert property ($fell(comparator_raw) ##0 (comparator_on && !comparator_raw) [*5]
    |-> !comparator_output_pin_o) else $error("level missed a fall");
  cover property ($rose(comparator_output_pin_o));
  cover property (pslverr);
  cover property (stop_mode ##1 !comparator_on);
endmodule : acc_comparator_ctrl_checker
bind acc_comparator_ctrl acc_comparator_ctrl_checker u_chk (.*);

/* File: acc_consts.svh */
`ifndef ACC_CONSTS_SVH
`define ACC_CONSTS_SVH

// ---------------------------------------------------------------------------
// register map
// ---------------------------------------------------------------------------
`define ACC_ADDR_W          12
`define ACC_OFF_CTRL        12'h000
`define ACC_OFF_IRQ_STATUS  12'h004
`define ACC_OFF_IRQ_MASK    12'h008

// ---------------------------------------------------------------------------
// status and control field positions
// ---------------------------------------------------------------------------
`define ACC_BIT_ENABLE      7
`define ACC_BIT_REFSEL      6
`define ACC_BIT_FLAG        5
`define ACC_BIT_IRQEN       4
`define ACC_BIT_LEVEL       3
`define ACC_BIT_PINEN       2
`define ACC_MODE_HI         1
`define ACC_MODE_LO         0

// ---------------------------------------------------------------------------
// interrupt status and mask layout
// ---------------------------------------------------------------------------
`define ACC_IRQ_BIT_EVENT   0

// ---------------------------------------------------------------------------
// reset values
// ---------------------------------------------------------------------------
`define ACC_CTRL_RST        8'h00
`define ACC_MODE_RST        2'h0

`endif

/* File: acc_pkg.sv */
package acc_pkg;

  // event edge selection
  typedef enum logic [1:0] {
    ACC_MODE_FALL0  = 2'b00,
    ACC_MODE_RISE   = 2'b01,
    ACC_MODE_FALL2  = 2'b10,
    ACC_MODE_EITHER = 2'b11
  } acc_mode_e;

endpackage : acc_pkg

/* File: test_analog_comparator_control.sv */
`timescale 1ns/10ps
module test_analog_comparator_control;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stop_mode = 1'b0, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  pstrb = 4'hF;
  logic        pready, pslverr, comparator_raw, comparator_on, reference_select, compare_irq, irq;
  logic        comparator_output_pin_o, comparator_output_pin_oe_n;
  int          pos_mv = 400, neg_mv = 500, bandgap_mv = 400, err_count = 0, total_checks = 0;
  // bus clock; the analog stand-in answers at once
  always #25 pclk = ~pclk;
  acc_comparator_ctrl DUT (.*);
  acc_analog_model    u_ana (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  // one transfer; ready and data are taken at the rising edge that completes the access
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    if (pready !== 1'b1) err_count++;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask : rc
  // move the pin input, then allow the synchroniser and flag stages to settle
  task automatic ana(input int p);
    pos_mv <= p;
    repeat (6) @(posedge pclk);
  endtask : ana
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rc(12'h000, 32'hFF, 32'h00);
    chk(comparator_output_pin_oe_n, 1'b1);
    rc(12'h00C, 32'hFFFFFFFF, 32'h0);
    chk(er, 1'b1);
    apb(1'b1, 12'h00C, 32'hFF);
    chk(er, 1'b1);
    // rising mode, input goes high: one event, irq request and pin on
    apb(1'b1, 12'h000, 32'h95);
    ana(600);
    rc(12'h000, 32'hFF, 32'hBD);
    chk({compare_irq, comparator_output_pin_o, comparator_output_pin_oe_n, comparator_on}, 4'hD);
    apb(1'b1, 12'h000, 32'h9D);
    rc(12'h000, 32'hFF, 32'hBD);
    rc(12'h004, 32'h1, 32'h1);
    chk(irq, 1'b0);
    apb(1'b1, 12'h008, 32'h1);
    apb(1'b1, 12'h000, 32'hB1);
    rc(12'h000, 32'hFF, 32'h99);
    chk({irq, compare_irq, comparator_output_pin_oe_n}, 3'b101);
    apb(1'b1, 12'h004, 32'h1);
    rc(12'h004, 32'h1, 32'h0);
    chk(irq, 1'b0);
    // every edge mode against a fall and a rise, irq request off
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, 12'h000, 32'hA0 | m);
      ana(400);
      rc(12'h000, 32'h20, (m == 1) ? 32'h0 : 32'h20);
      chk(compare_irq, 1'b0);
      apb(1'b1, 12'h000, 32'hA0 | m);
      ana(600);
      rc(12'h000, 32'h20, m[0] ? 32'h20 : 32'h0);
    end
    // bandgap sits below the inverting input, the pin above it
    apb(1'b1, 12'h000, 32'hC0);
    ana(600);
    rc(12'h000, 32'h08, 32'h0);
    chk(reference_select, 1'b1);
    apb(1'b1, 12'h000, 32'h80);
    ana(600);
    rc(12'h000, 32'h08, 32'h08);
    apb(1'b1, 12'h000, 32'h00);
    rc(12'h000, 32'h08, 32'h0);
    chk(comparator_on, 1'b0);
    // stop wins over a software enable, so input swings make no event
    stop_mode <= 1'b1;
    apb(1'b1, 12'h000, 32'hA3);
    ana(400);
    ana(600);
    rc(12'h000, 32'h28, 32'h0);
    chk(comparator_on, 1'b0);
    summarize();
  end
endmodule : test_analog_comparator_control
